// File: rtl/drc_ctrl.v
`timescale 1ns/1ps
`include "drc_defs.vh"
// Operation
// - row-only refresh drives the row address when the row strobe falls.
// - refresh_during_read_hold keeps write high, output enable low, column low.
// - write strobe stays high through every column-first refresh.
// - after power-up issue eight row-only or column-first wake-up cycles.
// - wait at least 100 us after power-up before wake-up cycles.
// - refresh all 1024 rows within every 16 ms.
// - repeat the eight-cycle wake-up after any refresh interval violation.
module drc_ctrl #(
	parameter PAUSE_CYC    = `DRC_PAUSE_CYC,
	parameter INTERVAL_CYC = `DRC_REF_INTERVAL_CYC,
	parameter TREF_CYC     = `DRC_TREF_CYC,
	parameter WAKE_CYCLES  = `DRC_WAKE_CYCLES,
	parameter ADDR_W       = `DRC_ADDR_W
) (
	clock,
	reset,
	req_valid,
	req_kind,
	req_ready,
	use_column_first,
	ready_for_access,
	in_test_mode,
	refresh_overdue,
	row_strobe_n,
	col_strobe_n,
	write_strobe_n,
	out_enable_n,
	multiplexed_addr
);
	input  wire              clock;
	input  wire              reset;
	input  wire              req_valid;
	input  wire [1:0]        req_kind;
	output wire              req_ready;
	input  wire              use_column_first;
	output wire              ready_for_access;
	output wire              in_test_mode;
	output wire              refresh_overdue;
	output reg               row_strobe_n;
	output reg               col_strobe_n;
	output reg               write_strobe_n;
	output reg               out_enable_n;
	output reg  [ADDR_W-1:0] multiplexed_addr;

	localparam ST_PAUSE = 3'h0;
	localparam ST_IDLE  = 3'h1;
	localparam ST_SETUP = 3'h2;
	localparam ST_ROW   = 3'h3;
	localparam ST_HOLD  = 3'h4;
	localparam ST_PRE   = 3'h5;

	localparam [31:0] PHASE_LAST = `DRC_PHASE_CYC - 1;

	////////////////////////////////////////////////////////////////////////
	reg [2:0]        state_ff;
	reg [2:0]        nxt_state;
	reg [1:0]        kind_ff;
	reg [1:0]        nxt_kind;
	reg              own_ff;
	reg              nxt_own;
	reg [2:0]        phase_ff;
	reg [2:0]        nxt_phase;
	reg [31:0]       pause_ff;
	reg [3:0]        wake_ff;
	reg [ADDR_W-1:0] row_ff;
	reg [31:0]       age_ff;
	reg              test_ff;
	reg              debt_ff;
	wire             tick;
	wire             row_done;
	wire             wake_kind;
	wire             awake;

	assign awake            = ({28'h0, wake_ff} == WAKE_CYCLES);
	assign ready_for_access = awake;
	assign in_test_mode     = test_ff;
	assign refresh_overdue  = (age_ff >= TREF_CYC);
	assign req_ready        = (state_ff == ST_IDLE) && awake && !debt_ff && !tick;
	assign row_done         = (state_ff == ST_PRE) && (phase_ff == 3'h0);
	assign wake_kind        = (kind_ff == `DRC_KIND_ROW_ONLY) || (kind_ff == `DRC_KIND_COL_FIRST);

	drc_tick #(
		.PERIOD (INTERVAL_CYC)
	) u_tick (
		.clock   (clock),
		.reset   (reset),
		.restart (state_ff == ST_PAUSE),
		.tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencing
	always @* begin
		nxt_state = state_ff;
		nxt_kind  = kind_ff;
		nxt_own   = own_ff;
		nxt_phase = (phase_ff == 3'h0) ? 3'h0 : phase_ff - 3'h1;
		case (state_ff)
			ST_PAUSE: begin
				if (pause_ff >= PAUSE_CYC) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (!awake || debt_ff || tick) begin
					// wake-up uses only row-only or column-first
					nxt_kind  = use_column_first ? `DRC_KIND_COL_FIRST : `DRC_KIND_ROW_ONLY;
					nxt_own   = 1'b1;
					nxt_state = ST_SETUP;
					nxt_phase = PHASE_LAST[2:0];
				end else if (req_valid) begin
					nxt_kind  = req_kind;
					nxt_own   = 1'b0;
					nxt_state = ST_SETUP;
					nxt_phase = PHASE_LAST[2:0];
				end
			end
			ST_SETUP: begin
				if (phase_ff == 3'h0) begin
					nxt_state = ST_ROW;
					nxt_phase = PHASE_LAST[2:0];
				end
			end
			ST_ROW: begin
				if (phase_ff == 3'h0) begin
					nxt_state = ST_HOLD;
					nxt_phase = PHASE_LAST[2:0];
				end
			end
			ST_HOLD: begin
				if (phase_ff == 3'h0) begin
					nxt_state = ST_PRE;
					nxt_phase = PHASE_LAST[2:0];
				end
			end
			ST_PRE: begin
				if (phase_ff == 3'h0) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clock) begin
		if (reset) begin
			state_ff <= ST_PAUSE;
			kind_ff  <= 2'h0;
			own_ff   <= 1'b0;
			phase_ff <= 3'h0;
			pause_ff <= 32'h0;
		end else begin
			state_ff <= nxt_state;
			kind_ff  <= nxt_kind;
			own_ff   <= nxt_own;
			phase_ff <= nxt_phase;
			if (state_ff == ST_PAUSE) begin
				pause_ff <= pause_ff + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bookkeeping: wake count, row counter, refresh age, test mode
	always @(posedge clock) begin
		if (reset) begin
			wake_ff <= 4'h0;
			row_ff  <= {ADDR_W{1'b0}};
			age_ff  <= 32'h0;
			test_ff <= 1'b1;
			debt_ff <= 1'b0;
		end else begin
			if (age_ff < TREF_CYC) begin
				age_ff <= age_ff + 32'h1;
			end
			if (refresh_overdue) begin
				wake_ff <= 4'h0;
			end else if (row_done && wake_kind && !awake) begin
				wake_ff <= wake_ff + 4'h1;
			end
			if (tick && state_ff != ST_PAUSE) begin
				debt_ff <= 1'b1;
			end else if (row_done && own_ff) begin
				debt_ff <= 1'b0;
			end
			if (row_done) begin
				row_ff <= row_ff + {{(ADDR_W-1){1'b0}}, 1'b1};
				if (row_ff == {ADDR_W{1'b1}}) begin
					age_ff <= 32'h0;
				end
				if (kind_ff == `DRC_KIND_TEST_ENTRY) begin
					test_ff <= 1'b1;
				end else if (wake_kind) begin
					test_ff <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive
	always @(posedge clock) begin
		if (reset) begin
			row_strobe_n     <= 1'b1;
			col_strobe_n     <= 1'b1;
			write_strobe_n   <= 1'b1;
			out_enable_n     <= 1'b1;
			multiplexed_addr <= {ADDR_W{1'b0}};
		end else begin
			row_strobe_n   <= !(nxt_state == ST_ROW || nxt_state == ST_HOLD);
			write_strobe_n <= 1'b1;
			out_enable_n   <= 1'b1;
			col_strobe_n   <= 1'b1;
			case (nxt_kind)
				`DRC_KIND_ROW_ONLY: begin
					multiplexed_addr <= row_ff;
				end
				`DRC_KIND_COL_FIRST: begin
					col_strobe_n <= !(nxt_state == ST_SETUP || nxt_state == ST_ROW);
				end
				`DRC_KIND_HIDDEN: begin
					col_strobe_n <= (nxt_state == ST_IDLE || nxt_state == ST_PAUSE);
					out_enable_n <= (nxt_state == ST_IDLE || nxt_state == ST_PAUSE);
				end
				default: begin
					col_strobe_n   <= !(nxt_state == ST_SETUP || nxt_state == ST_ROW);
					write_strobe_n <= !(nxt_state == ST_SETUP || nxt_state == ST_ROW
						|| nxt_state == ST_HOLD);
				end
			endcase
		end
	end
endmodule

// File: rtl/drc_defs.vh
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH
// timing figures and derived cycle counts, 25 MHz clock
`define DRC_CLK_MHZ          25
`define DRC_PAUSE_US         100
`define DRC_PAUSE_CYC        (`DRC_PAUSE_US * `DRC_CLK_MHZ)
`define DRC_TREF_MS          16
`define DRC_ROWS             1024
`define DRC_TREF_CYC         (`DRC_TREF_MS * 1000 * `DRC_CLK_MHZ)
`define DRC_REF_INTERVAL_CYC (`DRC_TREF_CYC / `DRC_ROWS)
`define DRC_WAKE_CYCLES      8
`define DRC_ADDR_W           10
`define DRC_PHASE_CYC        4
// refresh kinds on the command port
`define DRC_KIND_ROW_ONLY    2'h0
`define DRC_KIND_COL_FIRST   2'h1
`define DRC_KIND_HIDDEN      2'h2
`define DRC_KIND_TEST_ENTRY  2'h3
`endif

// File: rtl/drc_tick.v
`timescale 1ns/1ps
module drc_tick #(
	parameter PERIOD = 390
) (
	clock,
	reset,
	restart,
	tick
);
	input  wire clock;
	input  wire reset;
	input  wire restart;
	output wire tick;

	reg [31:0] cnt_ff;

	assign tick = (cnt_ff == PERIOD - 1);

	always @(posedge clock) begin
		if (reset || restart || tick) begin
			cnt_ff <= 32'h0;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end
endmodule

// File: verification/drc_dram_model.sv
`timescale 1ns/1ps
module drc_dram_model (
	input wire        row_strobe_n,
	input wire        col_strobe_n,
	input wire        write_strobe_n,
	input wire  [9:0] multiplexed_addr,
	output reg        test_mode,
	output reg  [9:0] last_row,
	output integer    wake_cnt,
	output wire       data_hiz
);
	reg [9:0] row_cnt;
	initial begin
		test_mode = 1'b1;
		row_cnt = 10'h000;
		wake_cnt = 0;
	end
	assign data_hiz = col_strobe_n;
	always @(negedge row_strobe_n) begin
		if (col_strobe_n) begin
			last_row = multiplexed_addr;
			test_mode = 1'b0;
		end else begin
			last_row = row_cnt;
			row_cnt = row_cnt + 10'h001;
			test_mode = !write_strobe_n;
		end
		if (col_strobe_n || write_strobe_n)
			wake_cnt = wake_cnt + 1;
	end
endmodule

// File: verification/drc_props.sv
`timescale 1ns/1ps
module drc_props (
	input wire clock,
	input wire reset,
	input wire req_valid,
	input wire req_ready,
	input wire ready_for_access,
	input wire row_strobe_n,
	input wire col_strobe_n,
	input wire write_strobe_n,
	input wire out_enable_n
);
	reg [3:0] falls_ff;
	// counts row strobe falls since reset, saturating
	always @(posedge clock)
		if (reset)
			falls_ff <= 4'h0;
		else if ($fell(row_strobe_n) && falls_ff != 4'hF)
			falls_ff <= falls_ff + 4'h1;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	a_pause_quiet: assert property ($fell(reset) |-> (row_strobe_n && !ready_for_access)[*8])
		else $error("strobe or ready during pause");
	a_wake_count: assert property (ready_for_access |-> falls_ff >= 4'h8)
		else $error("ready before eight wake cycles");
	a_take_to_row: assert property (req_valid && req_ready |-> ##[5:6] $fell(row_strobe_n))
		else $error("row strobe late");
	a_row_length: assert property ($fell(row_strobe_n) |-> !row_strobe_n[*8] ##1 row_strobe_n)
		else $error("row strobe width");
	a_row_only_col: assert property ($fell(row_strobe_n) && col_strobe_n |-> col_strobe_n[*8])
		else $error("column strobe in row-only");
	a_hidden_hold: assert property ($fell(row_strobe_n) && !out_enable_n |-> write_strobe_n && !col_strobe_n)
		else $error("refresh_during_read_hold strobes");
	a_col_first: assert property ($fell(col_strobe_n) && out_enable_n |-> ##4 $fell(row_strobe_n))
		else $error("column before row spacing");
	a_cbr_write_high: assert property ($fell(col_strobe_n) && write_strobe_n && out_enable_n |-> write_strobe_n[*8])
		else $error("write fell in refresh");
	a_test_entry: assert property ($fell(row_strobe_n) && !write_strobe_n |-> !col_strobe_n && out_enable_n)
		else $error("write low outside test entry");
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
	reg        clock;
	reg        reset;
	reg        req_valid;
	reg  [1:0] req_kind;
	reg        use_column_first;
	wire       req_ready, ready_for_access, in_test_mode, refresh_overdue;
	wire       row_strobe_n, col_strobe_n, write_strobe_n, out_enable_n;
	wire [9:0] multiplexed_addr;
	wire       test_mode;
	wire [9:0] last_row;
	wire       data_hiz;
	localparam TB_PAUSE = 20;
	integer    wake_cnt;
	integer    failures;
	integer    checked;
	drc_ctrl #(.PAUSE_CYC(TB_PAUSE), .INTERVAL_CYC(40), .TREF_CYC(50000)) dut_u (
		.clock(clock), .reset(reset), .req_valid(req_valid), .req_kind(req_kind), .req_ready(req_ready),
		.use_column_first(use_column_first), .ready_for_access(ready_for_access), .in_test_mode(in_test_mode),
		.refresh_overdue(refresh_overdue), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n), .multiplexed_addr(multiplexed_addr));
	drc_dram_model model_u (.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n), .multiplexed_addr(multiplexed_addr), .test_mode(test_mode),
		.last_row(last_row), .wake_cnt(wake_cnt), .data_hiz(data_hiz));
	task report_and_stop;
		begin
			$display("checked %0d failures %0d", checked, failures);
			if (failures == 0 && checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
		begin
			checked = checked + 1;
			if (e !== s) begin
				failures = failures + 1;
				$display("unexpected %0s exp %0h got %0h", nm, e, s);
			end
		end
	endtask
	task wait_hi(input integer sel);
		integer n;
		begin
			n = 0;
			while ((sel ? req_ready : ready_for_access) !== 1'b1 && n < 2000) begin
				@(negedge clock);
				n = n + 1;
			end
			if (n == 2000) begin
				failures = failures + 1;
				report_and_stop;
			end
		end
	endtask
	task t_power_up(input cf);
		integer w0;
		integer n;
		begin
			@(posedge clock);
			reset <= 1'b1;
			use_column_first <= cf;
			repeat (8) @(posedge clock);
			reset <= 1'b0;
			@(negedge clock);
			w0 = wake_cnt;
			chk("dut_tm", 1, in_test_mode);
			chk("ready", 0, ready_for_access);
			n = 0;
			while (wake_cnt == w0 && n < 2000) begin
				@(negedge clock);
				n = n + 1;
			end
			if (n == 2000) begin
				failures = failures + 1;
				report_and_stop;
			end
			chk("pause", 1, n >= TB_PAUSE);
			wait_hi(0);
			chk("wakes", 1, wake_cnt - w0 >= 8);
			chk("tmode", 0, test_mode);
			chk("dut_tm", 0, in_test_mode);
			$display("power-up done");
		end
	endtask
	task t_kind(input [1:0] k, input exp);
		begin
			@(posedge clock);
			req_valid <= 1'b1;
			req_kind <= k;
			@(negedge clock);
			wait_hi(1);
			@(posedge clock);
			req_valid <= 1'b0;
			repeat (8) @(negedge clock);
			chk("hiz", k == 2'h0, data_hiz);
			if (k == 2'h0)
				chk("row", multiplexed_addr, last_row);
			repeat (9) @(negedge clock);
			chk("tmode", exp, test_mode);
			chk("dut_tm", exp, in_test_mode);
			chk("overdue", 0, refresh_overdue);
			$display("refresh kind %0d done", k);
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req_kind = 2'h0;
		use_column_first = 1'b0;
		failures = 0;
		checked = 0;
		t_power_up(1'b0);
		t_kind(2'h3, 1'b1);
		t_kind(2'h0, 1'b0);
		t_kind(2'h3, 1'b1);
		t_kind(2'h1, 1'b0);
		t_kind(2'h2, 1'b0);
		t_power_up(1'b1);
		t_kind(2'h0, 1'b0);
		report_and_stop;
	end
endmodule
bind drc_ctrl drc_props props_u (.clock(clock), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
	.ready_for_access(ready_for_access), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
	.write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n));
